// ===== src/eeprom_access_control.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_access_control #(
  parameter int unsigned ATOMIC_CYCLES_P = nvm_pkg::ATOMIC_CYCLES,
  parameter int unsigned SPLIT_CYCLES_P = nvm_pkg::SPLIT_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic por_n_i,
  input wire logic [5:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic cpu_irq_enable_i,
  output logic [7:0] io_rdata_o,
  output logic cpu_stall_o,
  output logic nvm_ready_irq_o
);
  localparam logic [nvm_pkg::TIMER_W-1:0] ATOMIC_LOAD = ATOMIC_CYCLES_P[nvm_pkg::TIMER_W-1:0];
  localparam logic [nvm_pkg::TIMER_W-1:0] SPLIT_LOAD = SPLIT_CYCLES_P[nvm_pkg::TIMER_W-1:0];

  // Reset seen through the pin synchroniser; apart from mode while idle, the engine itself only clears on power-on.
  logic rst_s1_q;
  logic rst_s2_q;
  logic rst_s3_q;
  logic in_reset;

  always_ff @(posedge clock_i or negedge por_n_i) begin
    if (!por_n_i) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
      rst_s3_q <= 1'b0;
    end else begin
      rst_s1_q <= rst_n_i;
      rst_s2_q <= rst_s1_q;
      rst_s3_q <= rst_s2_q;
    end
  end
  assign in_reset = !rst_s2_q && !rst_s3_q;

  // Register file state, cleared by the system reset.
  logic [8:0] addr_q;
  logic [8:0] addr_d;
  logic [7:0] data_q;
  logic [7:0] data_d;
  logic rie_q;
  logic rie_d;
  logic mpe_q;
  logic mpe_d;
  logic [2:0] mpe_cnt_q;
  logic [2:0] mpe_cnt_d;
  logic re_q;
  logic re_d;
  logic rvalid_q;
  logic rvalid_d;
  logic [2:0] stall_cnt_q;
  logic [2:0] stall_cnt_d;
  logic [7:0] rdata_d;
  logic irq_d;
  logic stall_d;

  // Programming engine state, kept across the system reset; mode is kept only while busy.
  nvm_pkg::eng_state_t state_q;
  nvm_pkg::eng_state_t state_d;
  logic [1:0] mode_q;
  logic [1:0] mode_d;
  logic [8:0] eng_addr_q;
  logic [8:0] eng_addr_d;
  logic [7:0] eng_data_q;
  logic [7:0] eng_data_d;
  logic [1:0] eng_mode_q;
  logic [1:0] eng_mode_d;

  logic wr_ok;
  logic ctrl_wr;
  logic busy;
  logic prog_go;
  logic read_go;
  logic tmr_done;
  logic [7:0] mem_rdata;
  logic [1:0] wmode;
  logic [nvm_pkg::TIMER_W-1:0] tmr_load_val;

  assign busy = (state_q == nvm_pkg::ENG_BUSY);
  assign wr_ok = io_wr_i && rst_n_i && !in_reset;
  assign ctrl_wr = wr_ok && (io_addr_i == nvm_pkg::CTRL_OFS);
  assign wmode = io_wdata_i[nvm_pkg::MODE_MSB:nvm_pkg::MODE_LSB];
  assign prog_go = ctrl_wr && io_wdata_i[nvm_pkg::PROG_ENABLE_BIT] && mpe_q && !busy
                   && (wmode != nvm_pkg::MODE_RESERVED);
  assign read_go = ctrl_wr && io_wdata_i[nvm_pkg::READ_STROBE_BIT] && !busy && !re_q && !prog_go;
  assign tmr_load_val = (wmode == nvm_pkg::MODE_ATOMIC) ? ATOMIC_LOAD : SPLIT_LOAD;

  always_comb begin
    addr_d = addr_q;
    data_d = data_q;
    rie_d = rie_q;
    mpe_d = mpe_q;
    mpe_cnt_d = mpe_cnt_q;
    re_d = re_q;
    rvalid_d = 1'b0;
    stall_cnt_d = stall_cnt_q;
    rdata_d = nvm_pkg::DATA_RESET;
    if (wr_ok && !busy && (io_addr_i == nvm_pkg::ADDR_HIGH_OFS)) begin
      addr_d[8] = io_wdata_i[0];
    end
    if (wr_ok && !busy && (io_addr_i == nvm_pkg::ADDR_LOW_OFS)) begin
      addr_d[7:0] = io_wdata_i;
    end
    if (wr_ok && (io_addr_i == nvm_pkg::DATA_OFS)) begin
      data_d = io_wdata_i;
    end
    if (ctrl_wr) begin
      rie_d = io_wdata_i[nvm_pkg::RIE_BIT];
    end
    if (mpe_q) begin
      if (mpe_cnt_q == 3'h0) begin
        mpe_d = 1'b0;
      end else begin
        mpe_cnt_d = mpe_cnt_q - 3'h1;
      end
    end else if (ctrl_wr && io_wdata_i[nvm_pkg::MASTER_BIT]) begin
      mpe_d = 1'b1;
      mpe_cnt_d = nvm_pkg::MPE_WINDOW_CYCLES - 3'h1;
    end
    if (read_go) begin
      re_d = 1'b1;
    end
    if (re_q && !rvalid_q) begin
      rvalid_d = 1'b1;
    end
    // fetched byte lands in data register
    if (re_q && rvalid_q) begin
      data_d = mem_rdata;
      re_d = 1'b0;
    end
    if (prog_go) begin
      stall_cnt_d = nvm_pkg::STALL_PROG_CYCLES;
    end else if (read_go) begin
      stall_cnt_d = nvm_pkg::STALL_READ_CYCLES;
    end else if (stall_cnt_q != 3'h0) begin
      stall_cnt_d = stall_cnt_q - 3'h1;
    end
    if (io_rd_i) begin
      unique case (io_addr_i)
        nvm_pkg::ADDR_HIGH_OFS: rdata_d = {7'h00, addr_q[8]};
        nvm_pkg::ADDR_LOW_OFS: rdata_d = addr_q[7:0];
        nvm_pkg::DATA_OFS: rdata_d = data_q;
        nvm_pkg::CTRL_OFS: rdata_d = {2'h0, mode_q, rie_q, mpe_q, busy, re_q};
        default: rdata_d = nvm_pkg::DATA_RESET;
      endcase
    end
    stall_d = (stall_cnt_d != 3'h0);
    irq_d = rie_d && cpu_irq_enable_i && (state_d == nvm_pkg::ENG_IDLE);
  end

  // address cleared here only to keep state defined
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_q <= nvm_pkg::ADDR_RESET;
      data_q <= nvm_pkg::DATA_RESET;
      rie_q <= 1'b0;
      mpe_q <= 1'b0;
      mpe_cnt_q <= 3'h0;
      re_q <= 1'b0;
      rvalid_q <= 1'b0;
      stall_cnt_q <= 3'h0;
      cpu_stall_o <= 1'b0;
      io_rdata_o <= nvm_pkg::DATA_RESET;
      nvm_ready_irq_o <= 1'b0;
    end else begin
      addr_q <= addr_d;
      data_q <= data_d;
      rie_q <= rie_d;
      mpe_q <= mpe_d;
      mpe_cnt_q <= mpe_cnt_d;
      re_q <= re_d;
      rvalid_q <= rvalid_d;
      stall_cnt_q <= stall_cnt_d;
      cpu_stall_o <= stall_d;
      io_rdata_o <= rdata_d;
      nvm_ready_irq_o <= irq_d;
    end
  end

  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    eng_addr_d = eng_addr_q;
    eng_data_d = eng_data_q;
    eng_mode_d = eng_mode_q;
    unique case (state_q)
      nvm_pkg::ENG_IDLE: begin
        // mode writes only accepted when idle
        if (ctrl_wr) begin
          mode_d = wmode;
        end
        // mode returns to atomic on reset when idle
        if (in_reset) begin
          mode_d = nvm_pkg::MODE_RESET;
        end
        if (prog_go) begin
          state_d = nvm_pkg::ENG_BUSY;
          eng_addr_d = addr_q;
          eng_data_d = data_q;
          eng_mode_d = wmode;
        end
      end
      nvm_pkg::ENG_BUSY: begin
        // system reset does not reach here
        if (tmr_done) begin
          state_d = nvm_pkg::ENG_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge por_n_i) begin
    if (!por_n_i) begin
      state_q <= nvm_pkg::ENG_IDLE;
      mode_q <= nvm_pkg::MODE_RESET;
      eng_addr_q <= nvm_pkg::ADDR_RESET;
      eng_data_q <= nvm_pkg::DATA_RESET;
      eng_mode_q <= nvm_pkg::MODE_RESET;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
      eng_addr_q <= eng_addr_d;
      eng_data_q <= eng_data_d;
      eng_mode_q <= eng_mode_d;
    end
  end

  prog_timer #(
    .WIDTH(nvm_pkg::TIMER_W)
  ) u_timer (
    .clock_i(clock_i),
    .rst_n_i(por_n_i),
    .load_i(prog_go),
    .load_val_i(tmr_load_val),
    .done_o(tmr_done)
  );

  nvm_array u_array (
    .clock_i(clock_i),
    .rst_n_i(por_n_i),
    .we_i(busy && tmr_done),
    .mode_i(eng_mode_q),
    .waddr_i(eng_addr_q),
    .wdata_i(eng_data_q),
    .re_i(re_q && !rvalid_q),
    .raddr_i(addr_q),
    .rdata_o(mem_rdata)
  );

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i || !por_n_i);

  sequence stall_two_s;
    cpu_stall_o [*2] ##1 !cpu_stall_o;
  endsequence

  sequence stall_four_s;
    cpu_stall_o [*4] ##1 !cpu_stall_o;
  endsequence

  mpe_window_a: assert property ($rose(mpe_q) |-> mpe_q [*4] ##1 !mpe_q)
    else $error("master enable window is not four cycles");
  start_needs_mpe_a: assert property ($rose(busy) |-> $past(mpe_q))
    else $error("programming started without master enable");
  mode_hold_a: assert property (busy && $past(busy) |-> $stable(mode_q))
    else $error("mode changed while programming");
  addr_hold_a: assert property (busy && $past(busy) |-> $stable(addr_q))
    else $error("address changed while programming");
  prog_stall_a: assert property ($rose(busy) |-> stall_two_s)
    else $error("program start did not stall two cycles");
  read_stall_a: assert property (read_go |=> stall_four_s)
    else $error("read strobe did not stall four cycles");
  read_refuse_a: assert property (busy && ctrl_wr && !re_q |=> !re_q)
    else $error("read strobe accepted while busy");
  strobe_clear_a: assert property ($rose(re_q) |-> re_q ##1 re_q ##1 !re_q)
    else $error("read strobe did not clear after the read");
  read_data_a: assert property ($fell(re_q) |-> data_q == $past(mem_rdata))
    else $error("data register missed the fetched byte");
  busy_irq_a: assert property (busy |-> !nvm_ready_irq_o)
    else $error("ready interrupt raised while programming");
  busy_end_a: assert property (busy && tmr_done |=> !busy)
    else $error("programming did not end at timer expiry");
endmodule : eeprom_access_control
`default_nettype wire

// ===== src/nvm_array.sv
`timescale 1ns/1ps
`default_nettype none
module nvm_array (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic we_i,
  input wire logic [1:0] mode_i,
  input wire logic [8:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic re_i,
  input wire logic [8:0] raddr_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem_q [nvm_pkg::NVM_DEPTH];
  logic [7:0] rdata_d;

  // The cell array has no reset: its contents are what nonvolatile storage held.
  always_ff @(posedge clock_i) begin
    if (we_i) begin
      unique case (mode_i)
        nvm_pkg::MODE_ATOMIC: mem_q[waddr_i] <= wdata_i;
        nvm_pkg::MODE_ERASE: mem_q[waddr_i] <= nvm_pkg::ERASED_BYTE;
        // A write without erase can only clear bits, so an unerased cell ends up corrupt.
        nvm_pkg::MODE_WRITE: mem_q[waddr_i] <= mem_q[waddr_i] & wdata_i;
        default: mem_q[waddr_i] <= mem_q[waddr_i];
      endcase
    end
  end

  always_comb begin
    rdata_d = rdata_o;
    if (re_i) begin
      rdata_d = mem_q[raddr_i];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= nvm_pkg::DATA_RESET;
    end else begin
      rdata_o <= rdata_d;
    end
  end
endmodule : nvm_array
`default_nettype wire

// ===== src/nvm_pkg.sv
`default_nettype none
package nvm_pkg;

  // Clock and programming times.
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned ATOMIC_TIME_NS = 3400000;
  localparam int unsigned SPLIT_TIME_NS = 1800000;
  localparam int unsigned ATOMIC_CYCLES = ATOMIC_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned SPLIT_CYCLES = SPLIT_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W = 17;

  // Register offsets in the I/O space of this block.
  localparam int unsigned IO_ADDR_W = 6;
  localparam logic [5:0] ADDR_HIGH_OFS = 6'h00;
  localparam logic [5:0] ADDR_LOW_OFS = 6'h01;
  localparam logic [5:0] DATA_OFS = 6'h02;
  localparam logic [5:0] CTRL_OFS = 6'h03;

  // Control register field positions.
  localparam int unsigned READ_STROBE_BIT = 0;
  localparam int unsigned PROG_ENABLE_BIT = 1;
  localparam int unsigned MASTER_BIT = 2;
  localparam int unsigned RIE_BIT = 3;
  localparam int unsigned MODE_LSB = 4;
  localparam int unsigned MODE_MSB = 5;

  // Programming modes.
  localparam logic [1:0] MODE_ATOMIC = 2'h0;
  localparam logic [1:0] MODE_ERASE = 2'h1;
  localparam logic [1:0] MODE_WRITE = 2'h2;
  localparam logic [1:0] MODE_RESERVED = 2'h3;

  // Reset values and cycle counts.
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [8:0] ADDR_RESET = 9'h000;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [2:0] MPE_WINDOW_CYCLES = 3'h4;
  localparam logic [2:0] STALL_PROG_CYCLES = 3'h2;
  localparam logic [2:0] STALL_READ_CYCLES = 3'h4;

  localparam int unsigned NVM_DEPTH = 512;
  localparam int unsigned NVM_ADDR_W = 9;

  typedef enum logic {ENG_IDLE, ENG_BUSY} eng_state_t;

endpackage : nvm_pkg
`default_nettype wire

// ===== src/prog_timer.sv
`timescale 1ns/1ps
`default_nettype none
module prog_timer #(
  parameter int unsigned WIDTH = 17
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [WIDTH-1:0] load_val_i,
  output logic done_o
);
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  logic done_d;

  always_comb begin
    cnt_d = cnt_q;
    done_d = 1'b0;
    if (load_i) begin
      cnt_d = load_val_i;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
      done_d = (cnt_q == {{(WIDTH-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
      done_o <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      done_o <= done_d;
    end
  end
endmodule : prog_timer
`default_nettype wire

// ===== verif/cpu_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
  input wire logic clock_i,
  input wire logic cpu_stall_i,
  input wire logic [7:0] io_rdata_i,
  output logic [5:0] io_addr_o,
  output logic io_wr_o,
  output logic io_rd_o,
  output logic [7:0] io_wdata_o
);
  initial begin
    io_addr_o = 6'h00;
    io_wr_o = 1'b0;
    io_rd_o = 1'b0;
    io_wdata_o = 8'h00;
  end
  // A halted core issues nothing, so each access first waits out the stall.
  task automatic start(input logic [5:0] a);
    @(negedge clock_i);
    while (cpu_stall_i === 1'b1) @(negedge clock_i);
    @(posedge clock_i);
    io_addr_o <= a;
  endtask : start
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    start(a);
    io_wdata_o <= (a == nvm_pkg::CTRL_OFS) ? (d & 8'h3F) : d;
    io_wr_o <= 1'b1;
    @(posedge clock_i);
    io_wr_o <= 1'b0;
    io_wdata_o <= ~io_wdata_o;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    start(a);
    io_rd_o <= 1'b1;
    @(posedge clock_i);
    io_rd_o <= 1'b0;
    #1 d = io_rdata_i;
  endtask : rd
  task automatic wait_idle();
    logic [7:0] c;
    c = 8'h02;
    for (int i = 0; i < 300 && c[1] !== 1'b0; i++) rd(nvm_pkg::CTRL_OFS, c);
  endtask : wait_idle
endmodule : cpu_bus_model
`default_nettype wire

// ===== verif/eeprom_access_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_access_control_tb;
  localparam logic [5:0] A_HI = nvm_pkg::ADDR_HIGH_OFS;
  localparam logic [5:0] A_LO = nvm_pkg::ADDR_LOW_OFS;
  localparam logic [5:0] DAT = nvm_pkg::DATA_OFS;
  localparam logic [5:0] CTL = nvm_pkg::CTRL_OFS;
  localparam int N_AT = 40;
  localparam int N_SP = 30;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic por_n_i = 1'b0;
  logic irq_en = 1'b0;
  logic [5:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic cpu_stall;
  logic irq;
  int n_errors = 0;
  int total_checks = 0;
  int stall_n = 0;
  int cyc = 0;
  logic [7:0] v;
  always #25 clock_i = ~clock_i;
  always @(negedge clock_i) begin
    cyc <= cyc + 1;
    if (cpu_stall === 1'b1) stall_n <= stall_n + 1;
  end
  eeprom_access_control #(.ATOMIC_CYCLES_P(N_AT), .SPLIT_CYCLES_P(N_SP)) dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .por_n_i(por_n_i), .io_addr_i(io_addr),
    .io_wr_i(io_wr), .io_rd_i(io_rd), .io_wdata_i(io_wdata), .cpu_irq_enable_i(irq_en),
    .io_rdata_o(io_rdata), .cpu_stall_o(cpu_stall), .nvm_ready_irq_o(irq));
  cpu_bus_model cpu (
    .clock_i(clock_i), .cpu_stall_i(cpu_stall), .io_rdata_i(io_rdata), .io_addr_o(io_addr),
    .io_wr_o(io_wr), .io_rd_o(io_rd), .io_wdata_o(io_wdata));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic close_out();
    if (n_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic pulse_reset();
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clock_i);
  endtask : pulse_reset
  task automatic set_addr(input logic [8:0] a);
    cpu.wr(A_HI, {7'h00, a[8]});
    cpu.wr(A_LO, a[7:0]);
  endtask : set_addr
  task automatic rd_byte(input logic [8:0] a, input logic [7:0] exp);
    int s0;
    set_addr(a);
    s0 = stall_n;
    cpu.wr(CTL, 8'h01);
    cpu.rd(DAT, v);
    check("read byte", v, exp);
    check("read stall", stall_n - s0, 4);
    cpu.rd(CTL, v);
    check("strobe clear", v[0], 1'b0);
  endtask : rd_byte
  task automatic t_regs();
    cpu.rd(CTL, v);
    check("ctrl reset", v, 8'h00);
    cpu.rd(DAT, v);
    check("data reset", v, 8'h00);
    cpu.wr(A_HI, 8'hFF);
    cpu.rd(A_HI, v);
    check("addr high", v, 8'h01);
    cpu.wr(A_LO, 8'hA5);
    cpu.rd(A_LO, v);
    check("addr low", v, 8'hA5);
    cpu.rd(6'h04, v);
    check("unmapped read", v, 8'h00);
  endtask : t_regs
  task automatic t_window();
    cpu.wr(CTL, 8'h04);
    cpu.rd(CTL, v);
    check("master set", v[2], 1'b1);
    repeat (6) @(posedge clock_i);
    cpu.rd(CTL, v);
    check("master clear", v[2], 1'b0);
    cpu.wr(CTL, 8'h02);
    cpu.rd(CTL, v);
    check("late start", v[1], 1'b0);
    cpu.wr(CTL, 8'h34);
    cpu.wr(CTL, 8'h36);
    cpu.rd(CTL, v);
    check("reserved mode", v[1], 1'b0);
  endtask : t_window
  task automatic t_irq();
    cpu.wr(CTL, 8'h08);
    @(posedge clock_i);
    irq_en <= 1'b1;
    repeat (3) @(negedge clock_i);
    check("irq on", irq, 1'b1);
    @(posedge clock_i);
    irq_en <= 1'b0;
    repeat (3) @(negedge clock_i);
    check("irq global off", irq, 1'b0);
    @(posedge clock_i);
    irq_en <= 1'b1;
    cpu.wr(CTL, 8'h00);
    repeat (3) @(negedge clock_i);
    check("irq local off", irq, 1'b0);
  endtask : t_irq
  task automatic prog_chk(input logic [1:0] m, input logic [8:0] a, input logic [7:0] d, input logic [7:0] e);
    int t0;
    int n;
    int s0;
    n = (m == 2'h0) ? N_AT : N_SP;
    set_addr(a);
    cpu.wr(DAT, d);
    cpu.wr(CTL, {2'h0, m, 4'hC});
    s0 = stall_n;
    cpu.wr(CTL, {2'h0, m, 4'hE});
    t0 = cyc;
    cpu.rd(CTL, v);
    check("busy", v[1], 1'b1);
    check("prog stall", stall_n - s0, 2);
    check("irq busy", irq, 1'b0);
    cpu.wr(CTL, {2'h0, ~m, 4'h8});
    cpu.rd(CTL, v);
    check("mode locked", v[5:4], m);
    cpu.wr(A_LO, ~a[7:0]);
    cpu.rd(A_LO, v);
    check("addr locked", v, a[7:0]);
    s0 = stall_n;
    cpu.wr(CTL, {2'h0, m, 4'h9});
    cpu.rd(CTL, v);
    check("read refused", stall_n - s0, 0);
    cpu.wait_idle();
    check("duration", (cyc - t0 >= n) && (cyc - t0 <= n + 8), 1'b1);
    repeat (2) @(negedge clock_i);
    check("irq ready", irq, 1'b1);
    rd_byte(a, e);
  endtask : prog_chk
  task automatic t_reset_mid();
    set_addr(9'h033);
    cpu.wr(CTL, 8'h14);
    cpu.wr(CTL, 8'h16);
    pulse_reset();
    cpu.rd(CTL, v);
    check("mode kept", v[5:4], 2'h1);
    check("prog survives", v[1], 1'b1);
    cpu.rd(DAT, v);
    check("data cleared", v, 8'h00);
    cpu.wait_idle();
    pulse_reset();
    cpu.rd(CTL, v);
    check("mode cleared", v[5:4], 2'h0);
    rd_byte(9'h033, nvm_pkg::ERASED_BYTE);
  endtask : t_reset_mid
  initial begin
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    por_n_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    t_regs();
    t_window();
    t_irq();
    prog_chk(2'h0, 9'h1A5, 8'h5A, 8'h5A);
    prog_chk(2'h1, 9'h1A5, 8'h00, nvm_pkg::ERASED_BYTE);
    prog_chk(2'h2, 9'h1A5, 8'h3C, 8'h3C);
    prog_chk(2'h0, 9'h0A5, 8'h77, 8'h77);
    rd_byte(9'h1A5, 8'h3C);
    t_reset_mid();
    close_out();
  end
  // The whole run needs a few hundred cycles; this bound only cuts a hang.
  initial begin
    repeat (20000) @(posedge clock_i);
    n_errors++;
    close_out();
  end
endmodule : eeprom_access_control_tb
`default_nettype wire
